//--- include/can_rrs_pkg.sv
`default_nettype none
package can_rrs_pkg;
    // Slot array geometry
    localparam int SLOTS = 16;
    localparam int SLOT_W = 4;
    localparam int ID_W = 29;
    localparam int STD_LSB = 18;
    localparam int DLC_W = 4;
    localparam int TS_W = 16;

    // Slot control code bit positions
    localparam int CTL_TR_BIT = 7;
    localparam int CTL_RR_BIT = 6;
    localparam int CTL_RM_BIT = 5;
    localparam int CTL_RL_BIT = 4;

    // Slot control codes
    localparam logic [7:0] CODE_CLEAR = 8'h00;
    localparam logic [7:0] CODE_RX_REPLY = 8'h60;
    localparam logic [7:0] CODE_RX_NOREPLY = 8'h70;

    // First and last slot of the search, first slot without auto reply in basic mode
    localparam logic [SLOT_W-1:0] FIRST_SLOT = 4'h0;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 4'hF;
    localparam logic [SLOT_W-1:0] BASIC_NOREPLY_SLOT = 4'hE;

    // Reset value of all per-slot flags
    localparam logic [SLOTS-1:0] FLAGS_RST = 16'h0000;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic ide;
        logic rtr;
        logic [DLC_W-1:0] dlc;
    } rx_frame_t;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic [ID_W-1:0] id;
        logic ide;
        logic [DLC_W-1:0] dlc;
    } tx_req_t;

    typedef struct packed {
        logic wr;
        logic [SLOT_W-1:0] slot;
        logic [7:0] code;
    } ctl_wr_t;

    typedef struct packed {
        logic wr;
        logic [SLOT_W-1:0] slot;
        logic [ID_W-1:0] id;
        logic ide;
    } cfg_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEARCH,
        ST_STORE,
        ST_FINISH
    } rx_state_t;
endpackage
`default_nettype wire

//--- rtl/slot_match.sv
`timescale 1ns/10ps
`default_nettype none
module slot_match (
    // Slot setup
    input wire logic armed,
    input wire logic [can_rrs_pkg::ID_W-1:0] slot_id,
    input wire logic slot_ide,
    input wire logic [can_rrs_pkg::ID_W-1:0] id_mask,
    // Frame under test
    input wire can_rrs_pkg::rx_frame_t frame,
    // Result
    output logic hit
);
    logic [can_rrs_pkg::ID_W-1:0] diff;
    logic [can_rrs_pkg::ID_W-1:0] care;

    always_comb begin
        diff = (frame.id ^ slot_id) & id_mask;
        care = diff;
        // Standard frames carry no extended bits to compare
        if (!frame.ide) begin
            care[can_rrs_pkg::STD_LSB-1:0] = '0;
        end
        hit = armed && frame.rtr && (frame.ide == slot_ide) &&
              (care == '0);
    end
endmodule
`default_nettype wire

//--- rtl/can_remote_rx.sv
`timescale 1ns/10ps
`default_nettype none
module can_remote_rx (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Software control
    input wire can_rrs_pkg::ctl_wr_t ctl,
    input wire can_rrs_pkg::cfg_wr_t cfg,
    input wire logic [can_rrs_pkg::ID_W-1:0] id_mask,
    input wire logic basic_mailbox_mode,
    input wire logic [can_rrs_pkg::SLOTS-1:0] irq_en,
    input wire logic [can_rrs_pkg::SLOTS-1:0] irq_clr,
    input wire logic [can_rrs_pkg::SLOTS-1:0] abort_req,
    input wire logic [can_rrs_pkg::SLOT_W-1:0] rd_slot,
    // Protocol engine
    input wire logic rx_valid,
    input wire can_rrs_pkg::rx_frame_t rx_frame,
    input wire logic [can_rrs_pkg::TS_W-1:0] ts_cnt,
    input wire logic intermission,
    input wire logic tx_ok,
    input wire logic tx_lost,
    // Transmit request
    output logic tx_start,
    output can_rrs_pkg::tx_req_t tx_req,
    // Slot status
    output logic [can_rrs_pkg::SLOTS-1:0] slot_active_flag,
    output logic [can_rrs_pkg::SLOTS-1:0] slot_done_flag,
    output logic [can_rrs_pkg::SLOTS-1:0] remote_active_flag,
    output logic [can_rrs_pkg::SLOTS-1:0] tx_pending,
    output logic [can_rrs_pkg::SLOTS-1:0] irq_status,
    output logic irq,
    output logic rx_busy,
    // Slot readback
    output logic [can_rrs_pkg::ID_W-1:0] rd_id,
    output logic rd_ide,
    output logic [can_rrs_pkg::DLC_W-1:0] rd_dlc,
    output logic [can_rrs_pkg::TS_W-1:0] rd_ts
);
    localparam int SL = can_rrs_pkg::SLOTS;
    localparam int SW = can_rrs_pkg::SLOT_W;
    localparam int IW = can_rrs_pkg::ID_W;
    localparam int DW = can_rrs_pkg::DLC_W;
    localparam int TW = can_rrs_pkg::TS_W;

    typedef struct packed {
        can_rrs_pkg::rx_state_t st;
        logic [SW-1:0] idx;
        can_rrs_pkg::rx_frame_t rx;
        logic [TW-1:0] rx_ts;
        logic [SL-1:0] rr;
        logic [SL-1:0] rm;
        logic [SL-1:0] rl;
        logic [SL-1:0] ra;
        logic [SL-1:0] act;
        logic [SL-1:0] done;
        logic [SL-1:0] pend;
        logic [SL-1:0] isr;
        logic [SL-1:0][IW-1:0] id;
        logic [SL-1:0] ide;
        logic [SL-1:0][DW-1:0] dlc;
        logic [SL-1:0][TW-1:0] ts;
        logic tx_busy;
        logic tx_start;
        can_rrs_pkg::tx_req_t tx;
        logic irq;
        logic rx_busy;
        logic [IW-1:0] rd_id;
        logic rd_ide;
        logic [DW-1:0] rd_dlc;
        logic [TW-1:0] rd_ts;
    } state_t;

    state_t q;
    state_t d;
    logic [SL-1:0] hit;
    logic [SL-1:0] armed;
    logic [SL-1:0] eligible;

    // A slot only competes while armed for remote reception
    assign armed = q.rr & q.rm & ~q.act;

    genvar g;
    generate
        for (g = 0; g < SL; g++) begin : g_match
            slot_match u_match (
                .armed(armed[g]),
                .slot_id(q.id[g]),
                .slot_ide(q.ide[g]),
                .id_mask(id_mask),
                .frame(q.rx),
                .hit(hit[g])
            );
        end
    endgenerate

    // Basic mode keeps the top two slots out of transmission
    always_comb begin
        eligible = q.pend;
        if (basic_mailbox_mode) begin
            eligible[SL-1] = 1'b0;
            eligible[SL-2] = 1'b0;
        end
    end

    always_comb begin
        logic [SW-1:0] s;
        logic found;
        logic reply_ok;
        s = '0;
        found = 1'b0;
        reply_ok = 1'b0;
        d = q;
        d.tx_start = 1'b0;
        // Clear first so a same-cycle hardware set wins
        d.isr = q.isr & ~irq_clr;

        // Software control code write
        if (ctl.wr) begin
            s = ctl.slot;
            d.rr[s] = ctl.code[can_rrs_pkg::CTL_RR_BIT];
            d.rm[s] = ctl.code[can_rrs_pkg::CTL_RM_BIT];
            d.rl[s] = ctl.code[can_rrs_pkg::CTL_RL_BIT];
            d.pend[s] = ctl.code[can_rrs_pkg::CTL_TR_BIT];
            d.done[s] = 1'b0;
            d.ra[s] = ctl.code[can_rrs_pkg::CTL_RM_BIT] &
                      (ctl.code[can_rrs_pkg::CTL_RR_BIT] |
                       ctl.code[can_rrs_pkg::CTL_TR_BIT]);
        end

        // Software ID setup, refused while the module holds the slot
        if (cfg.wr && !q.act[cfg.slot]) begin
            d.id[cfg.slot] = cfg.id;
            d.ide[cfg.slot] = cfg.ide;
        end

        // Receive side acceptance and store
        case (q.st)
            can_rrs_pkg::ST_IDLE: begin
                if (rx_valid) begin
                    d.rx = rx_frame;
                    d.rx_ts = ts_cnt;
                    d.idx = can_rrs_pkg::FIRST_SLOT;
                    d.st = can_rrs_pkg::ST_SEARCH;
                end
            end
            can_rrs_pkg::ST_SEARCH: begin
                if (hit[q.idx]) begin
                    d.st = can_rrs_pkg::ST_STORE;
                end else if (q.idx == can_rrs_pkg::LAST_SLOT) begin
                    d.st = can_rrs_pkg::ST_IDLE;
                end else begin
                    d.idx = q.idx + 4'h1;
                end
            end
            can_rrs_pkg::ST_STORE: begin
                d.act[q.idx] = 1'b1;
                d.done[q.idx] = 1'b1;
                // Data bytes stay as they were
                d.id[q.idx] = q.rx.id;
                d.dlc[q.idx] = q.rx.dlc;
                d.ts[q.idx] = q.rx_ts;
                d.st = can_rrs_pkg::ST_FINISH;
            end
            can_rrs_pkg::ST_FINISH: begin
                d.isr[q.idx] = 1'b1;
                d.ra[q.idx] = 1'b0;
                d.done[q.idx] = 1'b0;
                d.act[q.idx] = 1'b0;
                d.rr[q.idx] = 1'b0;
                d.rm[q.idx] = 1'b0;
                reply_ok = !q.rl[q.idx] &&
                           !(basic_mailbox_mode &&
                             q.idx >= can_rrs_pkg::BASIC_NOREPLY_SLOT);
                d.pend[q.idx] = reply_ok;
                d.st = can_rrs_pkg::ST_IDLE;
            end
            default: begin
                d.st = can_rrs_pkg::ST_IDLE;
            end
        endcase

        // Transmit selection at intermission
        if (intermission && !q.tx_busy) begin
            for (int i = SL - 1; i >= 0; i--) begin
                if (eligible[i]) begin
                    s = SW'(i);
                    found = 1'b1;
                end
            end
            if (found) begin
                d.tx_busy = 1'b1;
                d.tx_start = 1'b1;
                d.act[s] = 1'b1;
                d.tx.slot = s;
                d.tx.id = q.id[s];
                d.tx.ide = q.ide[s];
                d.tx.dlc = q.dlc[s];
            end
        end

        // Transmit outcome
        if (q.tx_busy && tx_lost) begin
            d.tx_busy = 1'b0;
            d.act[q.tx.slot] = 1'b0;
            if (abort_req[q.tx.slot]) begin
                d.pend[q.tx.slot] = 1'b0;
            end
            // Otherwise pend stays set for the next round
        end else if (q.tx_busy && tx_ok) begin
            d.tx_busy = 1'b0;
            d.act[q.tx.slot] = 1'b0;
            d.pend[q.tx.slot] = 1'b0;
            d.ra[q.tx.slot] = 1'b0;
            d.done[q.tx.slot] = 1'b1;
            d.isr[q.tx.slot] = 1'b1;
            d.ts[q.tx.slot] = ts_cnt;
        end

        d.rx_busy = (d.st != can_rrs_pkg::ST_IDLE);
        d.irq = |(d.isr & irq_en);

        // Registered readback of one slot
        d.rd_id = q.id[rd_slot];
        d.rd_ide = q.ide[rd_slot];
        d.rd_dlc = q.dlc[rd_slot];
        d.rd_ts = q.ts[rd_slot];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= can_rrs_pkg::ST_IDLE;
            q.rr <= can_rrs_pkg::FLAGS_RST;
            q.rm <= can_rrs_pkg::FLAGS_RST;
            q.ra <= can_rrs_pkg::FLAGS_RST;
            q.act <= can_rrs_pkg::FLAGS_RST;
            q.done <= can_rrs_pkg::FLAGS_RST;
            q.pend <= can_rrs_pkg::FLAGS_RST;
            q.isr <= can_rrs_pkg::FLAGS_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign tx_start = q.tx_start;
    assign tx_req = q.tx;
    assign slot_active_flag = q.act;
    assign slot_done_flag = q.done;
    assign remote_active_flag = q.ra;
    assign tx_pending = q.pend;
    assign irq_status = q.isr;
    assign irq = q.irq;
    assign rx_busy = q.rx_busy;
    assign rd_id = q.rd_id;
    assign rd_ide = q.rd_ide;
    assign rd_dlc = q.rd_dlc;
    assign rd_ts = q.rd_ts;
endmodule
`default_nettype wire

//--- tb/can_remote_rx_checker.sv
`timescale 1ns/10ps
`default_nettype none
module can_remote_rx_checker (
    // Clock, reset and inputs
    input wire logic core_clk,
    input wire logic rst,
    input wire can_rrs_pkg::ctl_wr_t ctl,
    input wire logic basic_mailbox_mode,
    input wire logic [15:0] irq_en,
    input wire logic rx_valid,
    // Outputs
    input wire logic tx_start,
    input wire can_rrs_pkg::tx_req_t tx_req,
    input wire logic [15:0] slot_active_flag,
    input wire logic [15:0] remote_active_flag,
    input wire logic [15:0] tx_pending,
    input wire logic [15:0] irq_status,
    input wire logic irq,
    input wire logic rx_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    arm_sets_ra_a: assert property (
        ctl.wr && ctl.code inside {8'h60, 8'h70}
        |=> remote_active_flag[$past(ctl.slot)]) else $error("ra not set");
    irq_follows_a: assert property (
        irq == |(irq_status & $past(irq_en))) else $error("irq level");
    start_active_a: assert property (
        tx_start |-> slot_active_flag[tx_req.slot]) else $error("not active");
    lowest_slot_a: assert property (
        tx_start |-> ($past(tx_pending) & ((16'h0001 << tx_req.slot)
        - 16'h0001)) == 16'h0000) else $error("not lowest");
    basic_reply_a: assert property (
        basic_mailbox_mode && tx_start |-> tx_req.slot < 4'hE)
        else $error("basic slot sent");
    rx_take_a: assert property (
        rx_valid && !rx_busy |=> rx_busy) else $error("frame not taken");
    rx_bound_a: assert property (
        $rose(rx_busy) |-> ##[1:24] !rx_busy) else $error("search hung");
    ist_clean_a: assert property (
        ((irq_status & ~$past(irq_status)) & (slot_active_flag
        | remote_active_flag)) == 16'h0000) else $error("flags left");
    tx_seen_c: cover property (tx_start);
    rx_done_c: cover property ($fell(rx_busy));
    irq_seen_c: cover property (irq);
endmodule
bind can_remote_rx can_remote_rx_checker chk_i (.core_clk, .rst, .ctl,
    .basic_mailbox_mode, .irq_en, .rx_valid, .tx_start, .tx_req,
    .slot_active_flag, .remote_active_flag, .tx_pending, .irq_status,
    .irq, .rx_busy);
`default_nettype wire

//--- tb/can_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module can_engine_model (
    // Clock and bus state
    input wire logic core_clk,
    input wire logic quiet,
    input wire logic lose,
    input wire logic tx_start,
    // Engine events
    output var logic rx_valid,
    output var can_rrs_pkg::rx_frame_t rx_frame,
    output var logic intermission,
    output var logic tx_ok,
    output var logic tx_lost
);
    int cnt = 0;
    int busy = 0;
    initial {rx_valid, rx_frame, intermission, tx_ok, tx_lost} = '0;
    // Frame shown one cycle, then inverted so a late sample shows up
    task automatic send(can_rrs_pkg::rx_frame_t fr);
        rx_frame <= fr;
        rx_valid <= 1'b1;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_frame <= ~fr;
    endtask
    // No intermission while a frame is on the bus or traffic is quiet
    always @(posedge core_clk) begin
        cnt <= (cnt + 1) % 12;
        intermission <= cnt == 0 && busy == 0 && !quiet;
        busy <= tx_start ? 6 : (busy > 0 ? busy - 1 : 0);
        tx_ok <= busy == 2 && !lose;
        tx_lost <= busy == 2 && lose;
    end
endmodule
`default_nettype wire

//--- tb/can_remote_rx_tb.sv
`timescale 1ns/10ps
`default_nettype none
module can_remote_rx_tb;
    localparam logic [28:0] RID = 29'h0ABC0000;
    // Reset starts unknown so its rise at time zero is an edge
    logic core_clk = 1'b0, rst, basic_mailbox_mode = 1'b0;
    logic lose = 1'b0, quiet = 1'b1, tx_start, irq, rx_busy, rd_ide;
    can_rrs_pkg::ctl_wr_t ctl = '0;
    can_rrs_pkg::cfg_wr_t cfg = '0;
    can_rrs_pkg::tx_req_t tx_req;
    logic [28:0] id_mask = '1, rd_id;
    logic [15:0] irq_en = 16'h0088, irq_clr = '0, ts_cnt = '0, rd_ts;
    logic [15:0] active, done, remote, pend, ist;
    logic [15:0] abort = '0;
    logic [15:0] e_arm = '0, e_rep = '0, e_pend = '0, e_ist = '0;
    logic [3:0] rd_slot = '0, rd_dlc;
    logic [31:0] rng = 32'h0000003F;
    int fails = 0, samples_checked = 0;
    int e_id[16], e_dlc[16], e_ide[16];
    wire logic rx_valid, intermission, tx_ok, tx_lost;
    wire can_rrs_pkg::rx_frame_t rx_frame;
    can_remote_rx DUT (.core_clk, .rst, .ctl, .cfg, .id_mask,
        .basic_mailbox_mode, .irq_en, .irq_clr, .abort_req(abort),
        .rd_slot, .rx_valid, .rx_frame, .ts_cnt, .intermission, .tx_ok,
        .tx_lost, .tx_start, .tx_req, .slot_active_flag(active),
        .slot_done_flag(done), .remote_active_flag(remote),
        .tx_pending(pend), .irq_status(ist), .irq, .rx_busy, .rd_id,
        .rd_ide, .rd_dlc, .rd_ts);
    can_engine_model eng (.core_clk, .quiet, .lose, .tx_start, .rx_valid,
        .rx_frame, .intermission, .tx_ok, .tx_lost);
    initial forever #2 core_clk = ~core_clk;
    function automatic logic [31:0] xs(logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_on(int w);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge core_clk);
            if ((w == 0 ? tx_start : w == 1 ? tx_ok | tx_lost : !rx_busy)
                === 1'b1)
                break;
        end
        if (n == 300) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic wr_ctl(int s, logic [7:0] c);
        ctl <= '{1'b1, s[3:0], c};
        @(posedge core_clk);
        ctl.wr <= 1'b0;
        @(posedge core_clk);
        e_arm[s] = c[6] & c[5];
        e_rep[s] = !c[4];
        e_pend[s] = c[7];
    endtask
    task automatic arm(int s, logic [28:0] id, logic ide, logic [7:0] c);
        wr_ctl(s, 8'h00);
        chk(active[s], 1'b0);
        cfg <= '{1'b1, s[3:0], id, ide};
        @(posedge core_clk);
        cfg.wr <= 1'b0;
        wr_ctl(s, c);
        chk(remote, e_arm);
        e_id[s] = id;
        e_ide[s] = ide;
    endtask
    task automatic rx(can_rrs_pkg::rx_frame_t fr);
        int k;
        logic [28:0] m;
        logic [15:0] t;
        m = fr.ide ? 29'h1FFFFFFF : 29'h1FFC0000;
        k = -1;
        // Walked downwards so the lowest matching slot is kept
        for (int i = 15; i >= 0; i--)
            if (e_arm[i] && fr.rtr && fr.ide == e_ide[i]
                && ((fr.id ^ e_id[i]) & m & id_mask) == 0)
                k = i;
        rng = xs(rng);
        t = rng[15:0];
        ts_cnt <= t;
        eng.send(fr);
        // Move the counter on so a late capture shows up
        ts_cnt <= ~t;
        wait_on(2);
        repeat (4) @(posedge core_clk);
        if (k >= 0) begin
            e_arm[k] = 1'b0;
            e_ist[k] = 1'b1;
            e_pend[k] = e_rep[k] && !(basic_mailbox_mode && k >= 14);
            e_dlc[k] = fr.dlc;
            e_id[k] = fr.id;
            rd_slot <= k[3:0];
            repeat (2) @(posedge core_clk);
            chk(rd_id & m, fr.id & m);
            chk(rd_dlc, fr.dlc);
            chk(rd_ide, fr.ide);
            chk(rd_ts, t);
            chk({active[k], done[k]}, 2'b00);
        end
        chk(ist, e_ist);
        chk(irq, |(e_ist & irq_en));
        chk(pend, e_pend);
        chk(remote, e_arm);
    endtask
    task automatic tx_one(logic l, logic ab);
        int s;
        logic [28:0] m;
        logic [15:0] t;
        s = 0;
        while (!e_pend[s])
            s++;
        m = e_ide[s] ? 29'h1FFFFFFF : 29'h1FFC0000;
        rng = xs(rng);
        t = rng[15:0];
        ts_cnt <= t;
        abort[s] <= ab;
        lose <= l;
        quiet <= 1'b0;
        wait_on(0);
        chk(tx_req.slot, s);
        chk(tx_req.id & m, e_id[s] & m);
        chk(tx_req.ide, e_ide[s]);
        chk(tx_req.dlc, e_dlc[s]);
        chk(active[s], 1'b1);
        wait_on(1);
        // Completion stamp must be the value at the ok edge
        ts_cnt <= ~t;
        quiet <= 1'b1;
        @(posedge core_clk);
        abort <= 16'h0000;
        chk(active[s], 1'b0);
        e_pend[s] = l && !ab;
        e_ist[s] = e_ist[s] | !l;
        chk(pend, e_pend);
        chk({ist, done[s]}, {e_ist, !l});
        rd_slot <= s[3:0];
        repeat (2) @(posedge core_clk);
        if (!l)
            chk(rd_ts, t);
    endtask
    initial begin
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(active | done | remote | pend | ist, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            arm(2, rng[28:0], 1'b1, 8'h60);
            rng = xs(rng);
            id_mask <= rng[31:3];
            @(posedge core_clk);
            rx('{29'(e_id[2] ^ (32'(rng[5]) << rng[4:0])), 1'b1, rng[6],
                rng[10:7]});
        end
        id_mask <= '1;
        for (int i = 0; i < 3; i++)
            arm(3 + 2 * i, RID, i == 2, i == 1 ? 8'h70 : 8'h60);
        rx('{RID, 1'b0, 1'b0, 4'h3});
        rx('{RID | 29'h5, 1'b1, 1'b1, 4'h8});
        rx('{RID, 1'b1, 1'b1, 4'h8});
        rx('{RID | 29'h155, 1'b0, 1'b1, 4'h2});
        rx('{RID | 29'h2AA, 1'b0, 1'b1, 4'hF});
        rx('{RID, 1'b0, 1'b1, 4'h1});
        irq_clr <= 16'hFFFF;
        @(posedge core_clk);
        irq_clr <= 16'h0000;
        @(posedge core_clk);
        e_ist = '0;
        chk({ist, irq}, 17'h00000);
        tx_one(1'b1, 1'b0);
        tx_one(1'b1, 1'b1);
        repeat (4)
            if (e_pend != 0)
                tx_one(1'b0, 1'b0);
        basic_mailbox_mode <= 1'b1;
        arm(4, RID, 1'b0, 8'h60);
        arm(14, RID, 1'b0, 8'h60);
        rx('{RID, 1'b0, 1'b1, 4'h6});
        rx('{RID, 1'b0, 1'b1, 4'h7});
        tx_one(1'b0, 1'b0);
        chk(pend, 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
